/* verilog/dpc_pkg.sv */
// Constants for the parameter channel codec
package dpc_pkg;
  // Register bus
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] REG_PARAM_ID  = 8'h00;
  localparam logic [7:0] REG_INDEX     = 8'h04;
  localparam logic [7:0] REG_VAL_HI    = 8'h08;
  localparam logic [7:0] REG_VAL_LO    = 8'h0C;
  localparam logic [7:0] REG_CTRL      = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h14;
  localparam logic [7:0] REG_FULL_NUM  = 8'h18;
  localparam logic [7:0] REG_RESULT    = 8'h1C;
  localparam logic [7:0] REG_ACYC_LEN  = 8'h20;
  localparam logic [7:0] REG_S2S_CFG   = 8'h24;
  localparam logic [7:0] REG_PEER_ADDR = 8'h28;
  localparam logic [7:0] REG_CONN      = 8'h2C;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // Telegram field positions
  localparam int CODE_LSB  = 12;
  localparam int NUM_MSB   = 10;
  localparam int SUB_LSB   = 8;
  localparam int DOBJ_LSB  = 10;
  localparam int CIDX_MSB  = 9;
  // Request codes
  localparam logic [3:0] CODE_READ  = 4'h6;
  localparam logic [3:0] CODE_WRITE = 4'h7;
  // Page index codes and their number offsets
  localparam logic [7:0]  PAGE_0     = 8'h00;
  localparam logic [7:0]  PAGE_2K    = 8'h80;
  localparam logic [7:0]  PAGE_6K    = 8'h90;
  localparam logic [7:0]  PAGE_8K    = 8'h20;
  localparam logic [7:0]  PAGE_10K   = 8'hA0;
  localparam logic [7:0]  PAGE_20K   = 8'h50;
  localparam logic [7:0]  PAGE_30K   = 8'hF0;
  localparam logic [15:0] OFFSET_0   = 16'h0000;
  localparam logic [15:0] OFFSET_2K  = 16'h07D0;
  localparam logic [15:0] OFFSET_6K  = 16'h1770;
  localparam logic [15:0] OFFSET_8K  = 16'h1F40;
  localparam logic [15:0] OFFSET_10K = 16'h2710;
  localparam logic [15:0] OFFSET_20K = 16'h4E20;
  localparam logic [15:0] OFFSET_30K = 16'h7530;
  // Limits
  localparam logic [8:0] ACYC_MAX_BYTES = 9'h0F0;
  localparam logic [3:0] PDW_MAX        = 4'hC;
  localparam logic [2:0] LINK_MAX       = 3'h4;
  localparam int         LINKS          = 4;
  // Control and status bits, configuration fields
  localparam int CTRL_GO      = 0;
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_ERR_CODE  = 2;
  localparam int ST_ERR_PAGE  = 3;
  localparam int ST_ERR_LEN   = 4;
  localparam int CFG_LINK_LSB = 0;
  localparam int CFG_PDW_LSB  = 4;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [8:0]  RST_LEN  = 9'h000;
  localparam logic [31:0] RST_PEER = 32'h0000_0000;
endpackage

/* verilog/dpc_page_map.sv */
// Page index to parameter number offset lookup
`timescale 1ns/1ps
`default_nettype none
module dpc_page_map (
  // Page index from the index word
  input  wire logic [7:0]  page_index,
  // Offset and legality
  output logic      [15:0] page_offset,
  output logic             page_valid
);
  // Fixed page table; any other code is unknown
  always_comb begin
    page_valid  = 1'b1;
    page_offset = dpc_pkg::OFFSET_0;
    case (page_index)
      dpc_pkg::PAGE_0:   page_offset = dpc_pkg::OFFSET_0;
      dpc_pkg::PAGE_2K:  page_offset = dpc_pkg::OFFSET_2K;
      dpc_pkg::PAGE_6K:  page_offset = dpc_pkg::OFFSET_6K;
      dpc_pkg::PAGE_8K:  page_offset = dpc_pkg::OFFSET_8K;
      dpc_pkg::PAGE_10K: page_offset = dpc_pkg::OFFSET_10K;
      dpc_pkg::PAGE_20K: page_offset = dpc_pkg::OFFSET_20K;
      dpc_pkg::PAGE_30K: page_offset = dpc_pkg::OFFSET_30K;
      default:           page_valid  = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* verilog/dpc_codec.sv */
// Parameter channel codec with register slave and parameter store port
// Summary of operation
// - request code sits in bits 15..12 of word one; 6 reads a field value.
// - number field sits in bits 10..0 of word one, page offset removed.
// - full number is field plus page offset; page 90 hex adds 6000.
// - subindex sits in bits 15..8 of word two; zero when not indexed.
// - request code 7 changes a field or word parameter value.
// - 32-bit value: bits 31..16 in word three, 15..0 in word four.
// - connector write: word four holds drive object 15..10, index 9..0.
// - publisher sends data straight to subscribers without the master.
// - slave-to-slave exchange only works with the fieldbus interface fitted.
// - at most twelve process data words per drive in slave exchange.
// - a publisher supports at most four slave-to-slave links.
// - peer addresses for slave exchange are readable in a parameter.
// - acyclic traffic runs beside cyclic data at lower priority.
// - acyclic read and write requests are limited to 240 bytes each.
`timescale 1ns/1ps
`default_nettype none
module dpc_codec (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // Write data channel
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Write response channel
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read address channel
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // Read data channel
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Parameter store
  output logic             store_valid,
  output logic             store_write,
  output logic [15:0]      store_number,
  output logic [7:0]       store_subindex,
  output logic [31:0]      store_value,
  input  wire logic        store_ready,
  input  wire logic [31:0] store_rdata,
  // Cyclic exchange and slave-to-slave
  input  wire logic        cyclic_active,
  input  wire logic        profibus_fitted_pin,
  output logic [3:0]       s2s_link_en,
  output logic [3:0]       s2s_pdw_limit
);
  typedef enum logic {DPC_IDLE, DPC_REQ} dpc_state_t;

  dpc_state_t  state;
  logic [15:0] param_id_word, index_word, value_high_word, value_low_word;
  logic [8:0]  acyc_len;
  logic [2:0]  link_count;
  logic [3:0]  pdw_count;
  logic [31:0] peer_address_list_param;
  logic        st_done, st_err_code, st_err_page, st_err_len;
  logic [31:0] result;
  logic        aw_full, w_full, fit_s1, fit_s2;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q, wr_merged, wr_bits, rd_word;
  logic [3:0]  wstrb_q;
  logic        do_write, wr_mapped, rd_mapped, start;
  logic [3:0]  request_code;
  logic [10:0] param_number_field;
  logic [15:0] page_offset, full_number;
  logic        page_valid, code_ok, len_ok;

  // Telegram field decode
  assign request_code       = param_id_word[15:dpc_pkg::CODE_LSB];
  assign param_number_field = param_id_word[dpc_pkg::NUM_MSB:0];
  assign full_number = 16'({5'h00, param_number_field}) + page_offset;
  assign code_ok = (request_code == dpc_pkg::CODE_READ) ||
                   (request_code == dpc_pkg::CODE_WRITE);
  assign len_ok  = (acyc_len <= dpc_pkg::ACYC_MAX_BYTES);

  dpc_page_map u_page (
    .page_index  (index_word[7:0]),
    .page_offset (page_offset),
    .page_valid  (page_valid)
  );

  // Byte lane merge
  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Register readback by address
  function automatic logic [31:0] reg_value(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      dpc_pkg::REG_PARAM_ID:  v = {16'h0000, param_id_word};
      dpc_pkg::REG_INDEX:     v = {16'h0000, index_word};
      dpc_pkg::REG_VAL_HI:    v = {16'h0000, value_high_word};
      dpc_pkg::REG_VAL_LO:    v = {16'h0000, value_low_word};
      dpc_pkg::REG_STATUS:    v = {27'h0000000, st_err_len, st_err_page,
                                   st_err_code, st_done, (state == DPC_REQ)};
      dpc_pkg::REG_FULL_NUM:  v = {8'h00, index_word[15:dpc_pkg::SUB_LSB],
                                   full_number};
      dpc_pkg::REG_RESULT:    v = result;
      dpc_pkg::REG_ACYC_LEN:  v = {23'h000000, acyc_len};
      dpc_pkg::REG_S2S_CFG:   v = {24'h000000, pdw_count, 1'b0, link_count};
      dpc_pkg::REG_PEER_ADDR: v = peer_address_list_param;
      dpc_pkg::REG_CONN:      v = {10'h000, value_low_word[15:dpc_pkg::DOBJ_LSB],
                                   6'h00, value_low_word[dpc_pkg::CIDX_MSB:0]};
      default:                v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Address legality
  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= dpc_pkg::REG_CONN);
  endfunction

  // Write path helpers
  assign do_write  = aw_full && w_full && !bvalid;
  assign wr_mapped = is_mapped(awaddr_q);
  assign wr_bits   = wmerge(32'h0000_0000, wdata_q, wstrb_q);
  assign start     = do_write && (awaddr_q == dpc_pkg::REG_CTRL) &&
                     wr_bits[dpc_pkg::CTRL_GO] && (state == DPC_IDLE);
  assign awready   = !aw_full;
  assign wready    = !w_full;
  assign arready   = !rvalid;

  // Address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full  <= 1'b0;
      w_full   <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_full  <= 1'b1;
        awaddr_q <= awaddr;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full  <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= dpc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_mapped ? dpc_pkg::RESP_OKAY : dpc_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read data
  // Readback and merge in a process, so any register change re-evaluates them
  always_comb begin
    rd_word   = reg_value(araddr);
    wr_merged = wmerge(reg_value(awaddr_q), wdata_q, wstrb_q);
  end
  assign rd_mapped = is_mapped(araddr);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= dpc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_mapped ? dpc_pkg::RESP_OKAY : dpc_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Telegram words and acyclic length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      param_id_word   <= dpc_pkg::RST_WORD;
      index_word      <= dpc_pkg::RST_WORD;
      value_high_word <= dpc_pkg::RST_WORD;
      value_low_word  <= dpc_pkg::RST_WORD;
      acyc_len        <= dpc_pkg::RST_LEN;
    end else if (do_write) begin
      case (awaddr_q)
        dpc_pkg::REG_PARAM_ID: param_id_word   <= wr_merged[15:0];
        dpc_pkg::REG_INDEX:    index_word      <= wr_merged[15:0];
        dpc_pkg::REG_VAL_HI:   value_high_word <= wr_merged[15:0];
        dpc_pkg::REG_VAL_LO:   value_low_word  <= wr_merged[15:0];
        dpc_pkg::REG_ACYC_LEN: acyc_len        <= wr_merged[8:0];
        default: ;
      endcase
    end
  end

  // Slave-to-slave configuration with clamped limits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_count              <= 3'h0;
      pdw_count               <= 4'h0;
      peer_address_list_param <= dpc_pkg::RST_PEER;
    end else if (do_write && (awaddr_q == dpc_pkg::REG_S2S_CFG)) begin
      link_count <= (wr_merged[dpc_pkg::CFG_LINK_LSB +: 3] > dpc_pkg::LINK_MAX) ?
                    dpc_pkg::LINK_MAX : wr_merged[dpc_pkg::CFG_LINK_LSB +: 3];
      pdw_count  <= (wr_merged[dpc_pkg::CFG_PDW_LSB +: 4] > dpc_pkg::PDW_MAX) ?
                    dpc_pkg::PDW_MAX : wr_merged[dpc_pkg::CFG_PDW_LSB +: 4];
    end else if (do_write && (awaddr_q == dpc_pkg::REG_PEER_ADDR)) begin
      peer_address_list_param <= wr_merged;
    end
  end

  // Interface-fitted pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fit_s1 <= 1'b0;
      fit_s2 <= 1'b0;
    end else begin
      fit_s1 <= profibus_fitted_pin;
      fit_s2 <= fit_s1;
    end
  end

  // Per-link publish enables, only with the interface fitted
  for (genvar i = 0; i < dpc_pkg::LINKS; i++) begin : g_link
    assign s2s_link_en[i] = fit_s2 && (3'(i) < link_count);
  end
  assign s2s_pdw_limit = fit_s2 ? pdw_count : 4'h0;

  // Request sequencer toward the parameter store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state          <= DPC_IDLE;
      store_write    <= 1'b0;
      store_number   <= 16'h0000;
      store_subindex <= 8'h00;
      store_value    <= 32'h0000_0000;
      result         <= 32'h0000_0000;
    end else begin
      unique case (state)
        DPC_IDLE: begin
          if (start && code_ok && page_valid && len_ok) begin
            state          <= DPC_REQ;
            store_write    <= (request_code == dpc_pkg::CODE_WRITE);
            store_number   <= full_number;
            store_subindex <= index_word[15:dpc_pkg::SUB_LSB];
            store_value    <= (request_code == dpc_pkg::CODE_WRITE) ?
                              {value_high_word, value_low_word} :
                              32'h0000_0000;
          end
        end
        DPC_REQ: begin
          if (store_valid && store_ready) begin
            state <= DPC_IDLE;
            if (!store_write) begin
              result <= store_rdata;
            end
          end
        end
      endcase
    end
  end

  // Cyclic data always goes first
  assign store_valid = (state == DPC_REQ) && !cyclic_active;

  // Sticky status; a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_done     <= 1'b0;
      st_err_code <= 1'b0;
      st_err_page <= 1'b0;
      st_err_len  <= 1'b0;
    end else begin
      if (do_write && (awaddr_q == dpc_pkg::REG_STATUS)) begin
        st_done     <= st_done     && !wr_bits[dpc_pkg::ST_DONE];
        st_err_code <= st_err_code && !wr_bits[dpc_pkg::ST_ERR_CODE];
        st_err_page <= st_err_page && !wr_bits[dpc_pkg::ST_ERR_PAGE];
        st_err_len  <= st_err_len  && !wr_bits[dpc_pkg::ST_ERR_LEN];
      end
      if (store_valid && store_ready) begin
        st_done <= 1'b1;
      end
      if (start && !code_ok) begin
        st_err_code <= 1'b1;
      end
      if (start && !page_valid) begin
        st_err_page <= 1'b1;
      end
      if (start && !len_ok) begin
        st_err_len <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_store_taken;
    store_valid && store_ready;
  endsequence

  sequence s_good_start;
    start && code_ok && page_valid && len_ok;
  endsequence

  a_read_code_go: assert property (s_good_start ##0 request_code == 4'h6
      |=> !store_write && store_value == 32'h0000_0000)
    else $error("read request not issued as a read with zero value");

  a_write_code_go: assert property (s_good_start ##0 request_code == 4'h7
      |=> store_write && store_value == {$past(value_high_word), $past(value_low_word)})
    else $error("write request value not formed from words three and four");

  a_bad_code_err: assert property (start && !code_ok |=> st_err_code && state == DPC_IDLE)
    else $error("unsupported request code not flagged");

  a_page_offset: assert property (s_good_start ##0 index_word[7:0] == 8'h90
      |=> store_number == 16'({5'h00, $past(param_number_field)}) + 16'h1770)
    else $error("page 90 hex did not add 6000");

  a_subindex_go: assert property (s_good_start |=> store_subindex == $past(index_word[15:8]))
    else $error("subindex not taken from word two");

  a_cyclic_first: assert property (cyclic_active |-> !store_valid)
    else $error("acyclic request served during cyclic data");

  a_store_done: assert property (s_store_taken |=> state == DPC_IDLE && st_done)
    else $error("store handshake did not finish the request");

  a_len_limit: assert property (start && acyc_len > 9'h0F0 |=> state == DPC_IDLE && st_err_len)
    else $error("oversized acyclic request accepted");

  a_pdw_limit: assert property (s2s_pdw_limit <= 4'hC)
    else $error("process data word limit above twelve");

  a_link_fit: assert property (!fit_s2 |-> s2s_link_en == 4'h0 && s2s_pdw_limit == 4'h0)
    else $error("slave exchange enabled without interface");

  a_link_count: assert property ($rose(s2s_link_en[3]) |-> link_count == 3'h4)
    else $error("fourth link enabled without four links configured");

  a_peer_read: assert property (arvalid && arready && araddr == 8'h28
      |=> rvalid && rdata == $past(peer_address_list_param))
    else $error("peer address list readback wrong");
endmodule
`default_nettype wire

/* bench/dpc_store_model.sv */
// Parameter store model that answers the codec's store requests
`timescale 1ns/1ps
`default_nettype none
module dpc_store_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Request from the codec
  input  wire logic        store_valid,
  input  wire logic [15:0] store_number,
  input  wire logic [7:0]  store_subindex,
  input  wire logic        slow,
  // Answer to the codec
  output logic             store_ready,
  output logic [31:0]      store_rdata
);
  logic [1:0]  wait_cnt;
  logic [31:0] junk;

  // Waiting cycles of a standing request, cleared after each take
  always_ff @(posedge aclk) begin
    if (!aresetn || !store_valid || store_ready) begin
      wait_cnt <= 2'h0;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end

  // Filler that changes every cycle while no request stands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      junk <= 32'hA5A5_0F0F;
    end else begin
      junk <= ~junk;
    end
  end

  // Prompt or slow take of a read or change request
  assign store_ready = store_valid && (!slow || wait_cnt == 2'h3);
  // Read value built from the full number and the subindex
  assign store_rdata = store_valid ? {store_number, store_subindex, 8'hA5} : junk;
endmodule
`default_nettype wire

/* bench/drive_param_channel_codec_tb.sv */
// Self-checking bench for the parameter channel codec
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module drive_param_channel_codec_tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, cyclic_active, fitted, slow;
  logic        store_valid, store_write, store_ready, t_wr;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  wstrb, s2s_link_en, s2s_pdw_limit;
  logic [7:0]  awaddr, araddr, store_subindex, t_sub;
  logic [15:0] store_number, t_num;
  logic [31:0] wdata, rdata, store_value, store_rdata, t_val, got, rnd;
  int          failures, total_checks, cycles, takes;
  int          offs[7] = '{0, 2000, 6000, 8000, 10000, 20000, 30000};
  logic [7:0]  pages[7] = '{8'h00, 8'h80, 8'h90, 8'h20, 8'hA0, 8'h50, 8'hF0};

  dpc_codec i_dpc_codec (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .store_valid(store_valid), .store_write(store_write),
    .store_number(store_number), .store_subindex(store_subindex),
    .store_value(store_value), .store_ready(store_ready), .store_rdata(store_rdata),
    .cyclic_active(cyclic_active), .profibus_fitted_pin(fitted),
    .s2s_link_en(s2s_link_en), .s2s_pdw_limit(s2s_pdw_limit));
  dpc_store_model i_dpc_store_model (.aclk(aclk), .aresetn(aresetn),
    .store_valid(store_valid), .store_number(store_number),
    .store_subindex(store_subindex), .slow(slow), .store_ready(store_ready),
    .store_rdata(store_rdata));

  // Clock at 100 MHz
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Cycle ceiling and capture of every store take
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      end_sim();
    end
    if (store_valid && store_ready) begin
      t_num = store_number;
      t_sub = store_subindex;
      t_val = store_value;
      t_wr = store_write;
      takes++;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Register write: address and data offered together, each held until taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((awvalid && !ta) || (wvalid && !tw)) begin
      @(negedge aclk);
      ta = ta || (awvalid && awready);
      tw = tw || (wvalid && wready);
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    resp = bresp;
    @(posedge aclk);
  endtask

  // Register read, one outstanding
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    d = rdata;
    resp = rresp;
    @(posedge aclk);
  endtask

  // One accepted request compared with the bench's own arithmetic
  task automatic run_req(input logic [3:0] c, input int pg, input logic stall);
    int n0, num;
    logic [10:0] fld;
    rnd = lfsr(rnd);
    // Field kept below 2000 so every page range stays legal
    fld = (rnd[10:0] < 11'h7D0) ? rnd[10:0] : {1'b0, rnd[9:0]};
    num = fld + offs[pg];
    axi_wr(8'h00, {16'h0, c, 1'b0, fld});
    axi_wr(8'h04, {16'h0, rnd[23:16], pages[pg]});
    axi_wr(8'h08, {16'h0, rnd[31:16]});
    axi_wr(8'h0C, {16'h0, rnd[15:0]});
    axi_rd(8'h18, got);
    `CHK("full_num", {8'h0, rnd[23:16], num[15:0]}, got)
    n0 = takes;
    cyclic_active <= stall;
    axi_wr(8'h10, 32'h0000_0001);
    repeat (4) @(posedge aclk);
    `CHK("stall_hold", stall ? n0 : n0 + 1, takes)
    cyclic_active <= 1'b0;
    while (takes == n0) @(negedge aclk);
    @(posedge aclk);
    `CHK("store_write", c == 4'h7, t_wr)
    `CHK("store_num", num[15:0], t_num)
    `CHK("store_sub", rnd[23:16], t_sub)
    `CHK("store_val", c == 4'h7 ? rnd : 32'h0, t_val)
    axi_rd(8'h14, got);
    `CHK("status_done", 32'h0000_0002, got)
    axi_rd(8'h1C, got);
    if (c == 4'h6) `CHK("result", {num[15:0], rnd[23:16], 8'hA5}, got)
    axi_wr(8'h14, 32'h0000_001E);
  endtask

  // A refused start sets its error flag and makes no store request
  task automatic bad_go(input logic [3:0] c, input logic [7:0] pg, input logic [31:0] len,
                        input logic [31:0] e);
    int n0;
    n0 = takes;
    axi_wr(8'h00, {16'h0, c, 12'h123});
    axi_wr(8'h04, {24'h0, pg});
    axi_wr(8'h20, len);
    axi_wr(8'h10, 32'h0000_0001);
    axi_rd(8'h14, got);
    `CHK("err_status", e, got)
    `CHK("err_no_req", n0, takes)
    axi_wr(8'h14, 32'h0000_001E);
    axi_wr(8'h20, 32'h0000_00F0);
  endtask

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cyclic_active, fitted, slow} = 9'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    rnd = 32'h2C3C8D3E;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 48; a += 4) begin
      axi_rd(a[7:0], got);
      `CHK("reset_val", 32'h0, got)
    end
    $display("test reset_values done");
    axi_wr(8'h20, 32'h0000_00F0);
    for (int p = 0; p < 7; p++) begin
      slow <= p[0];
      run_req(4'h6, p, 1'b0);
      run_req(4'h7, p, p == 3);
    end
    $display("test page_requests done");
    for (int c = 0; c < 16; c++) begin
      if (c != 6 && c != 7) bad_go(c[3:0], 8'h00, 32'h0000_00F0, 32'h0000_0004);
    end
    bad_go(4'h6, 8'h10, 32'h0000_00F0, 32'h0000_0008);
    bad_go(4'h7, 8'h00, 32'h0000_00F1, 32'h0000_0010);
    $display("test refusals done");
    axi_wr(8'h08, 32'h0000_02D2);
    axi_wr(8'h0C, {16'h0, 6'h3F, 10'h002});
    axi_rd(8'h2C, got);
    `CHK("connector", 32'h003F_0002, got)
    $display("test connector done");
    axi_wr(8'h24, 32'h0000_00F7);
    `CHK("s2s_unfitted", 8'h00, {s2s_link_en, s2s_pdw_limit})
    fitted <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("s2s_max", 8'hFC, {s2s_link_en, s2s_pdw_limit})
    axi_rd(8'h24, got);
    `CHK("s2s_cfg", 32'h0000_00C4, got)
    axi_wr(8'h24, 32'h0000_0052);
    `CHK("s2s_two", 8'h35, {s2s_link_en, s2s_pdw_limit})
    rnd = lfsr(rnd);
    axi_wr(8'h28, rnd);
    axi_rd(8'h28, got);
    `CHK("peer_addr", rnd, got)
    $display("test slave_exchange done");
    axi_wr(8'h30, rnd);
    `CHK("wr_unmapped", 2'h2, resp)
    axi_rd(8'h02, got);
    `CHK("rd_unmapped", 34'h2_0000_0000, {resp, got})
    $display("test unmapped done");
    end_sim();
  end
endmodule
`default_nettype wire
